// ===== core/hts_stamp_regs.sv
`timescale 1ns/100ps
module hts_stamp_regs (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        hot_event_i,
    input  wire logic                        hot_stamp_enable_i,
    input  wire logic                        hot_stamp_overwrite_select_i,
    input  wire logic                        hot_stamp_clear_i,
    input  wire logic [hts_pkg::MIN_W-1:0]   live_minutes_i,
    input  wire logic [hts_pkg::HOUR_W-1:0]  live_hours_i,
    input  wire logic [hts_pkg::DATE_W-1:0]  live_date_i,
    input  wire logic                        reg_rd_i,
    input  wire logic                        reg_wr_i,
    input  wire logic [7:0]                  reg_addr_i,
    input  wire logic [7:0]                  reg_wdata_i,
    output logic      [7:0]                  reg_rdata_o,
    output logic                             stamp_valid_o
);
    import hts_pkg::*;

    hts_snap_if snap ();

    logic       have_stamp;
    logic       next_have_stamp;
    logic       take;
    logic [7:0] next_rdata;
    logic       unused_wr;

    // write port exists for bus symmetry; stamps are read-only
    assign unused_wr = reg_wr_i ^ (|reg_wdata_i);

    // first-event mode locks after the first capture until cleared
    always_comb begin
        take = hot_event_i && hot_stamp_enable_i
               && (hot_stamp_overwrite_select_i || !have_stamp);
    end

    assign snap.take      = take;
    assign snap.clear     = hot_stamp_clear_i;
    assign snap.min_live  = live_minutes_i;
    assign snap.hour_live = live_hours_i;
    assign snap.date_live = live_date_i;

    hts_snap_store u_store (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .snap  (snap)
    );

    // set beats a same-cycle clear, matching the stamp store
    always_comb begin
        next_have_stamp = have_stamp;
        if (take) begin
            next_have_stamp = 1'b1;
        end else if (hot_stamp_clear_i) begin
            next_have_stamp = 1'b0;
        end
    end

    // read data registered; one cycle latency, zero when idle
    always_comb begin
        next_rdata = READ_IDLE;
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_STAMP_MINUTES: next_rdata = {1'b0, snap.min_held};
                ADDR_STAMP_HOURS:   next_rdata = {2'b00, snap.hour_held};
                ADDR_STAMP_DATE:    next_rdata = {2'b00, snap.date_held};
                default:            next_rdata = READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            have_stamp    <= 1'b0;
            reg_rdata_o   <= 8'h00;
            stamp_valid_o <= 1'b0;
        end else begin
            have_stamp    <= next_have_stamp;
            reg_rdata_o   <= next_rdata;
            stamp_valid_o <= next_have_stamp;
        end
    end

    // assertions watch the held stamps through the carrier, not the ports
    chk_write_ignored: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_wr_i && !take && !hot_stamp_clear_i)
        |=> ($stable(snap.min_held) && $stable(snap.hour_held)
            && $stable(snap.date_held)))
        else $error("stamp changed on host write");

    chk_min_top_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_MINUTES)
        |=> (reg_rdata_o[7] == 1'b0))
        else $error("minutes bit 7 not zero");

    chk_hour_top_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_HOURS)
        |=> (reg_rdata_o[7:6] == 2'b00))
        else $error("hours upper bits not zero");

    chk_date_top_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_DATE)
        |=> (reg_rdata_o[7:6] == 2'b00))
        else $error("date upper bits not zero");

    chk_min_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_MINUTES)
        |=> (reg_rdata_o[6:0] == $past(snap.min_held)))
        else $error("minutes read mismatch");

    chk_hour_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_HOURS)
        |=> (reg_rdata_o == {2'b00, $past(snap.hour_held)}))
        else $error("hours read mismatch");

    chk_date_read: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == ADDR_STAMP_DATE)
        |=> (reg_rdata_o == {2'b00, $past(snap.date_held)}))
        else $error("date read mismatch");

    chk_unmapped_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reg_rd_i && (reg_addr_i < ADDR_STAMP_MINUTES || reg_addr_i > ADDR_STAMP_DATE))
        |=> (reg_rdata_o == READ_IDLE))
        else $error("unmapped read not zero");

    chk_idle_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !reg_rd_i
        |=> (reg_rdata_o == READ_IDLE))
        else $error("read data not zero when idle");

    chk_no_cap_disabled: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!hot_stamp_enable_i && !hot_stamp_clear_i)
        |=> ($stable(snap.min_held) && $stable(snap.hour_held)
            && $stable(snap.date_held)))
        else $error("capture while disabled");

    chk_valid_disabled: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!hot_stamp_enable_i && !stamp_valid_o)
        |=> !stamp_valid_o)
        else $error("stamp valid rose while disabled");

    chk_first_kept: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (have_stamp && !hot_stamp_overwrite_select_i && !hot_stamp_clear_i)
        |=> ($stable(snap.min_held) && $stable(snap.hour_held)
            && $stable(snap.date_held)))
        else $error("first stamp overwritten");

    chk_latest_kept: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (hot_event_i && hot_stamp_enable_i && hot_stamp_overwrite_select_i)
        |=> (snap.hour_held == $past(live_hours_i) && stamp_valid_o))
        else $error("latest stamp not kept");

    chk_valid_holds: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (stamp_valid_o && !hot_stamp_clear_i)
        |=> stamp_valid_o)
        else $error("stamp valid dropped without clear");

    chk_clear_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (hot_stamp_clear_i && !take)
        |=> (snap.min_held == '0 && snap.hour_held == '0
            && snap.date_held == '0 && !stamp_valid_o))
        else $error("clear did not zero stamps");

    chk_snap_coherent: assert property (
        @(posedge clk_i) disable iff (rst_i)
        take
        |=> (snap.min_held == $past(live_minutes_i)
            && snap.hour_held == $past(live_hours_i)
            && snap.date_held == $past(live_date_i)))
        else $error("snapshot not coherent");

    chk_valid_on_take: assert property (
        @(posedge clk_i) disable iff (rst_i)
        take
        |=> stamp_valid_o)
        else $error("stamp valid not set by capture");

    chk_quiet_stable: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!hot_event_i && !hot_stamp_clear_i)
        |=> ($stable(snap.min_held) && $stable(snap.hour_held)
            && $stable(snap.date_held)))
        else $error("stamp changed without event");

    // main scenarios a run should reach
    cov_first_capture: cover property (
        @(posedge clk_i) disable iff (rst_i)
        take && !have_stamp);

    cov_overwrite: cover property (
        @(posedge clk_i) disable iff (rst_i)
        take && have_stamp);

    cov_clear_after: cover property (
        @(posedge clk_i) disable iff (rst_i)
        have_stamp ##1 hot_stamp_clear_i);

    cov_clear_with_take: cover property (
        @(posedge clk_i) disable iff (rst_i)
        take && hot_stamp_clear_i);

    cov_event_refused: cover property (
        @(posedge clk_i) disable iff (rst_i)
        hot_event_i && hot_stamp_enable_i && !take);
endmodule : hts_stamp_regs

// ===== core/hts_pkg.sv
package hts_pkg;
    localparam logic [7:0] ADDR_STAMP_MINUTES = 8'h21;
    localparam logic [7:0] ADDR_STAMP_HOURS   = 8'h22;
    localparam logic [7:0] ADDR_STAMP_DATE    = 8'h23;
    localparam int         MIN_W              = 7;
    localparam int         HOUR_W             = 6;
    localparam int         DATE_W             = 6;
    localparam logic [7:0] STAMP_RESET        = 8'h00;
    localparam logic [7:0] READ_IDLE          = 8'h00;
endpackage : hts_pkg

// ===== core/hts_snap_if.sv
`timescale 1ns/100ps
interface hts_snap_if;
    logic                       take;
    logic                       clear;
    logic [hts_pkg::MIN_W-1:0]  min_live;
    logic [hts_pkg::HOUR_W-1:0] hour_live;
    logic [hts_pkg::DATE_W-1:0] date_live;
    logic [hts_pkg::MIN_W-1:0]  min_held;
    logic [hts_pkg::HOUR_W-1:0] hour_held;
    logic [hts_pkg::DATE_W-1:0] date_held;
    modport ctrl (output take, clear, min_live, hour_live, date_live,
                  input min_held, hour_held, date_held);
    modport store (input take, clear, min_live, hour_live, date_live,
                   output min_held, hour_held, date_held);
endinterface : hts_snap_if

// ===== core/hts_snap_store.sv
`timescale 1ns/100ps
module hts_snap_store (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    hts_snap_if.store   snap
);
    import hts_pkg::*;
    logic [MIN_W-1:0]  next_min;
    logic [HOUR_W-1:0] next_hour;
    logic [DATE_W-1:0] next_date;
    logic [MIN_W-1:0]  min_q;
    logic [HOUR_W-1:0] hour_q;
    logic [DATE_W-1:0] date_q;

    // capture wins over a same-cycle clear so no event is lost
    always_comb begin
        next_min  = min_q;
        next_hour = hour_q;
        next_date = date_q;
        if (snap.take) begin
            next_min  = snap.min_live;
            next_hour = snap.hour_live;
            next_date = snap.date_live;
        end else if (snap.clear) begin
            next_min  = STAMP_RESET[MIN_W-1:0];
            next_hour = STAMP_RESET[HOUR_W-1:0];
            next_date = STAMP_RESET[DATE_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            min_q  <= '0;
            hour_q <= '0;
            date_q <= '0;
        end else begin
            min_q  <= next_min;
            hour_q <= next_hour;
            date_q <= next_date;
        end
    end

    assign snap.min_held  = min_q;
    assign snap.hour_held = hour_q;
    assign snap.date_held = date_q;
endmodule : hts_snap_store

// ===== testbench/hts_host_model.sv
`timescale 1ns/100ps
module hts_host_model (
    input  wire logic       clk_i,
    output logic            rd_o,
    output logic            wr_o,
    output logic            clr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    initial begin
        {rd_o, wr_o, clr_o, addr_o, wdata_o} = '0;
    end
    // released address and data lines flip and rd/wr drop to 0, so stale values never pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        {rd_o, wr_o, addr_o, wdata_o} = {~w, w, a, d};
        @(posedge clk_i);
        #1;
        {rd_o, wr_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
    endtask : xfer
    task automatic clr();
        @(posedge clk_i);
        #1;
        clr_o = 1'b1;
        @(posedge clk_i);
        #1;
        clr_o = 1'b0;
    endtask : clr
endmodule : hts_host_model

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import hts_pkg::*;
    typedef struct packed {
        logic        en;
        logic [18:0] live;
        logic [23:0] exp;
    } hts_row_t;
    logic       clk_i, rst_i, ev, en, ow, rd, wr, clr, valid;
    logic [6:0] lm;
    logic [5:0] lh, ld;
    logic [7:0] addr, wdata, rdata;
    int         error_cnt = 0;
    int         num_checks = 0;
    hts_row_t   rows [4] = '{
        '{1'b1, {7'h59, 6'h23, 6'h31}, 24'h592331},
        '{1'b1, {7'h00, 6'h00, 6'h01}, 24'h000001},
        '{1'b0, {7'h45, 6'h12, 6'h15}, 24'h000000},
        '{1'b1, {7'h30, 6'h19, 6'h28}, 24'h301928}};
    hts_stamp_regs u_hts_stamp_regs (.clk_i(clk_i), .rst_i(rst_i), .hot_event_i(ev),
        .hot_stamp_enable_i(en), .hot_stamp_overwrite_select_i(ow),
        .hot_stamp_clear_i(clr), .live_minutes_i(lm), .live_hours_i(lh),
        .live_date_i(ld), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .stamp_valid_o(valid));
    hts_host_model u_hts_host_model (.clk_i(clk_i), .rd_o(rd), .wr_o(wr),
        .clr_o(clr), .addr_o(addr), .wdata_o(wdata));
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp8
    task automatic rd_stamps(input logic [23:0] e);
        u_hts_host_model.xfer(1'b0, ADDR_STAMP_MINUTES, 8'h00);
        cmp8(rdata, e[23:16]);
        u_hts_host_model.xfer(1'b0, ADDR_STAMP_HOURS, 8'h00);
        cmp8(rdata, e[15:8]);
        u_hts_host_model.xfer(1'b0, ADDR_STAMP_DATE, 8'h00);
        cmp8(rdata, e[7:0]);
    endtask : rd_stamps
    task automatic hit(input logic [18:0] v);
        @(posedge clk_i);
        #1;
        {lm, lh, ld} = v;
        ev = 1'b1;
        @(posedge clk_i);
        #1;
        ev = 1'b0;
    endtask : hit
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, ev, en, ow, lm, lh, ld} = {1'b1, 22'h0};
        repeat (16) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd_stamps(24'h0);
        for (int i = 0; i < 4; i++) begin
            u_hts_host_model.clr();
            en = rows[i].en;
            ow = 1'b1;
            hit(rows[i].live);
            rd_stamps(rows[i].exp);
            $display("row %0d done", i);
        end
        ow = 1'b0;
        u_hts_host_model.clr();
        hit({7'h12, 6'h08, 6'h04});
        hit({7'h34, 6'h09, 6'h05});
        rd_stamps(24'h120804);
        ow = 1'b1;
        hit({7'h34, 6'h09, 6'h05});
        rd_stamps(24'h340905);
        $display("overwrite select done");
        for (int a = 33; a < 36; a++) u_hts_host_model.xfer(1'b1, 8'(a), 8'hff);
        rd_stamps(24'h340905);
        u_hts_host_model.xfer(1'b0, 8'h24, 8'h00);
        cmp8(rdata, READ_IDLE);
        cmp8({7'h00, valid}, 8'h01);
        rst_i = 1'b1;
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd_stamps(24'h0);
        // a capture must beat a clear in the same cycle
        fork
            u_hts_host_model.clr();
            hit({7'h45, 6'h10, 6'h11});
        join
        rd_stamps(24'h451011);
        cmp8({7'h00, valid}, 8'h01);
        $display("write and clear done");
        final_report();
    end
endmodule : testbench
